// ---- rtl/pbh_primary_bus.sv ----
// Purpose: primary bus master with strobe, ready, bus release and shutdown
// Assumes: the core side requests accesses synchronously on sys_clk
// Notes:   pins are split into input, output and output enable
`timescale 1ns/1ps
`default_nettype none
module pbh_primary_bus (
    input  wire logic                        sys_clk,
    input  wire logic                        reset_n,
    input  wire logic                        req_valid,
    input  wire logic                        req_read,
    input  wire logic [pbh_pkg::PBH_ADDR_W-1:0] req_addr,
    input  wire logic [pbh_pkg::PBH_DATA_W-1:0] req_wdata,
    output logic                             req_done,
    output logic [pbh_pkg::PBH_DATA_W-1:0]   rsp_rdata,
    output logic [pbh_pkg::PBH_ADDR_W-1:0]   fetch_addr,
    input  wire logic                        ack_instr,
    input  wire logic                        release_disable_bit,
    input  wire logic                        target_ready,
    input  wire logic                        bus_release_request,
    input  wire logic                        float_all_shutdown_n,
    output logic [pbh_pkg::PBH_ADDR_W-1:0]   address_bus,
    output logic                             address_oe,
    input  wire logic [pbh_pkg::PBH_DATA_W-1:0] data_bus_in,
    output logic [pbh_pkg::PBH_DATA_W-1:0]   data_bus_out,
    output logic                             data_oe,
    output logic                             access_strobe,
    output logic                             read_not_write,
    output logic                             ctrl_oe,
    output logic                             bus_release_grant,
    output logic                             grant_oe,
    output logic                             irq_service_marker,
    output logic                             marker_oe,
    output logic                             bus_phase_clock,
    output logic                             phase_oe
);
    import pbh_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0]            sync1_reg;
    logic [2:0]            sync2_reg;
    logic [PBH_DATA_W-1:0] data_s1_reg;
    logic [PBH_DATA_W-1:0] data_s2_reg;
    logic                  rdy_s;
    logic                  hold_s;
    logic                  shz_s;

    // two flops on each pin input
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg   <= 3'h6;
            sync2_reg   <= 3'h6;
            data_s1_reg <= 32'h00000000;
            data_s2_reg <= 32'h00000000;
        end else begin
            sync1_reg   <= {float_all_shutdown_n, bus_release_request, target_ready};
            sync2_reg   <= sync1_reg;
            data_s1_reg <= data_bus_in;
            data_s2_reg <= data_s1_reg;
        end
    end
    assign rdy_s  = sync2_reg[0];
    assign hold_s = ~sync2_reg[1];
    assign shz_s  = ~sync2_reg[2];

    // ----------------------------------------
    // access and release state machine
    // ----------------------------------------
    pbh_state_e state_reg;
    logic       hold_want;
    logic       busy_reg;
    assign hold_want = hold_s && !release_disable_bit;

    // strobe held until ready, release only from idle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg      <= PBH_IDLE;
            address_bus    <= PBH_RESET_VECTOR;
            data_bus_out   <= 32'h00000000;
            read_not_write <= PBH_DIR_READ;
            access_strobe  <= PBH_INACTIVE;
            req_done       <= 1'b0;
            rsp_rdata      <= 32'h00000000;
            busy_reg       <= 1'b0;
        end else begin
            req_done <= 1'b0;
            unique case (state_reg)
                PBH_IDLE: begin
                    if (hold_want) begin
                        state_reg <= PBH_RELEASED;
                    end else if (req_valid && !busy_reg) begin
                        state_reg      <= PBH_ACCESS;
                        address_bus    <= req_addr;
                        data_bus_out   <= req_wdata;
                        read_not_write <= req_read ? PBH_DIR_READ : PBH_DIR_WRITE;
                        access_strobe  <= PBH_ACTIVE_LOW;
                        busy_reg       <= 1'b1;
                    end else begin
                        busy_reg <= 1'b0;
                    end
                end
                PBH_ACCESS: begin
                    if (rdy_s) begin
                        state_reg     <= PBH_IDLE;
                        access_strobe <= PBH_INACTIVE;
                        req_done      <= 1'b1;
                        rsp_rdata     <= data_s2_reg;
                    end
                end
                PBH_RELEASED: begin
                    if (!hold_want) begin
                        state_reg <= PBH_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // grant, enables, marker, phase clock
    // ----------------------------------------
    logic [PBH_ADDR_W-1:0] fetch_next;
    assign fetch_next = PBH_RESET_VECTOR;

    // grant low only while released
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_release_grant <= PBH_INACTIVE;
            address_oe        <= 1'b0;
            data_oe           <= 1'b0;
            ctrl_oe           <= 1'b0;
            grant_oe          <= 1'b0;
            marker_oe         <= 1'b0;
            phase_oe          <= 1'b0;
            irq_service_marker <= PBH_INACTIVE;
            bus_phase_clock   <= 1'b0;
            fetch_addr        <= 24'h000000;
        end else begin
            bus_release_grant <= (state_reg == PBH_RELEASED && hold_want)
                                 ? PBH_ACTIVE_LOW : PBH_INACTIVE;
            address_oe <= !shz_s && state_reg != PBH_RELEASED;
            ctrl_oe    <= !shz_s && state_reg != PBH_RELEASED;
            // write data driven from the taking edge until ready ends it
            data_oe    <= !shz_s
                          && ((state_reg == PBH_IDLE && !hold_want && req_valid
                               && !busy_reg && !req_read)
                              || (state_reg == PBH_ACCESS && !rdy_s
                                  && read_not_write == PBH_DIR_WRITE));
            grant_oe   <= !shz_s;
            marker_oe  <= !shz_s;
            phase_oe   <= !shz_s;
            irq_service_marker <= ack_instr ? PBH_ACTIVE_LOW : PBH_INACTIVE;
            bus_phase_clock    <= ~bus_phase_clock;
            fetch_addr         <= fetch_next;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // strobe low at one sample
    sequence strobe_low_s;
        access_strobe == PBH_ACTIVE_LOW;
    endsequence

    // bus given away and still wanted
    sequence release_held_s;
        state_reg == PBH_RELEASED && hold_want;
    endsequence

    // release handshake
    grant_needs_float_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        bus_release_grant == PBH_ACTIVE_LOW |-> !address_oe && !ctrl_oe)
        else $error("grant low while bus driven");
    grant_after_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        release_held_s |=> bus_release_grant == PBH_ACTIVE_LOW)
        else $error("grant not given while released");
    release_waits_access_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_reg == PBH_ACCESS && !rdy_s |=> state_reg == PBH_ACCESS)
        else $error("access abandoned before ready");
    released_no_strobe_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_reg == PBH_RELEASED |-> access_strobe == PBH_INACTIVE)
        else $error("strobe during release");
    grant_returns_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !hold_want |-> ##[1:2] bus_release_grant == PBH_INACTIVE)
        else $error("grant not returned");

    // access timing
    strobe_stable_addr_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        strobe_low_s ##1 strobe_low_s |-> $stable(address_bus) && $stable(read_not_write))
        else $error("address moved under strobe");
    ready_ends_strobe_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_reg == PBH_ACCESS && rdy_s |=> access_strobe == PBH_INACTIVE && req_done)
        else $error("ready did not end access");
    done_ends_strobe_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        req_done |-> access_strobe == PBH_INACTIVE)
        else $error("strobe low after completion");
    read_dir_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_reg == PBH_IDLE && !hold_want && req_valid && !busy_reg && req_read
        |=> read_not_write == PBH_DIR_READ)
        else $error("read direction wrong");
    write_drives_data_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        access_strobe == PBH_ACTIVE_LOW && read_not_write == PBH_DIR_WRITE && !$past(shz_s)
        |-> data_oe)
        else $error("write data not driven");
    read_no_data_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        read_not_write == PBH_DIR_READ |-> !data_oe)
        else $error("data driven during read");

    // shutdown, marker, phase clock, vector
    shutdown_floats_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        shz_s |=> !address_oe && !data_oe && !ctrl_oe && !grant_oe && !phase_oe)
        else $error("pin driven in shutdown");
    shutdown_marker_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        shz_s |=> !marker_oe)
        else $error("marker driven in shutdown");
    marker_only_ack_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        irq_service_marker == PBH_ACTIVE_LOW |-> $past(ack_instr))
        else $error("marker without acknowledge");
    phase_toggles_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        bus_phase_clock |=> !bus_phase_clock)
        else $error("phase clock not halving");
    fetch_vector_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        fetch_addr == PBH_RESET_VECTOR)
        else $error("first fetch not at vector");
endmodule
`default_nettype wire

// ---- shared/pbh_pkg.sv ----
// Purpose: constants for the primary bus and bus release interface
// Assumes: one clock sys_clk at 200 MHz, asynchronous active-low reset
// Notes:   widths, vector address and pin encodings live here
// Operation
// - the address bus is 24 bits wide and data or instruction words are 32 bits.
// - read_not_write is high for a read cycle and low for a write cycle.
// - a low bus release request first lets an access in progress finish.
// - while released, address, data, strobe and direction float and no access starts.
// - the grant goes low once the outputs float and accesses are suspended.
// - the grant returns high when the request goes high or the disable bit is set.
// - reset low holds the block idle and release fetches from the reset vector.
// - float_all_shutdown places every pin in the high-impedance state.
// - irq_service_marker pulses only when the acknowledge instruction executes.
// - bus_phase_clock has twice the input clock period and floats in shutdown.
package pbh_pkg;
    localparam int          PBH_ADDR_W       = 24;
    localparam int          PBH_DATA_W       = 32;
    localparam logic [23:0] PBH_RESET_VECTOR = 24'h000000;
    localparam logic        PBH_DIR_READ     = 1'b1;
    localparam logic        PBH_DIR_WRITE    = 1'b0;
    localparam logic        PBH_ACTIVE_LOW   = 1'b0;
    localparam logic        PBH_INACTIVE     = 1'b1;
    typedef enum logic [1:0] {
        PBH_IDLE,
        PBH_ACCESS,
        PBH_RELEASED
    } pbh_state_e;
endpackage

// ---- testbench/pbh_target_model.sv ----
// Purpose: external target that answers strobed accesses
// Assumes: wait count set by the bench per access
// Notes:   a deselected data bus shows a changing pattern
`timescale 1ns/1ps
`default_nettype none
module pbh_target_model (
    input  wire logic        sys_clk,
    input  wire logic        access_strobe,
    input  wire logic        read_not_write,
    input  wire logic [23:0] address_bus,
    input  wire logic [3:0]  wait_cycles,
    output logic             target_ready,
    output logic [31:0]      data_bus_in
);
    logic [3:0]  wait_reg = 4'h0;
    logic [31:0] last_reg = 32'h0;
    // count wait cycles while strobed
    always @(posedge sys_clk) begin
        wait_reg <= (access_strobe === 1'b0) ? wait_reg + 4'h1 : 4'h0;
        last_reg <= data_bus_in;
    end
    // ready after the wait, dropped with the strobe
    assign target_ready = (access_strobe === 1'b0) && (wait_reg >= wait_cycles);
    // read data from the address, inverse of last value otherwise
    assign data_bus_in = (access_strobe === 1'b0 && read_not_write === 1'b1)
                       ? ({8'h00, address_bus} ^ 32'hC3C30000) : ~last_reg;
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for the primary bus block
// Assumes: 200 MHz sys_clk, target model on the pins
// Notes:   read data model is address xor a fixed mask
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pbh_pkg::*;
    logic sys_clk = 0, reset_n = 0, req_valid = 0, req_read = 0, ack_instr = 0;
    logic release_disable_bit = 0, bus_release_request = 1, float_all_shutdown_n = 1;
    logic [23:0] req_addr = 0, fetch_addr, address_bus;
    logic [31:0] req_wdata = 0, rsp_rdata, data_bus_in, data_bus_out, seed = 32'h63B3492E;
    logic [3:0]  wait_cycles = 0;
    logic req_done, address_oe, data_oe, access_strobe, read_not_write, ctrl_oe, target_ready;
    logic bus_release_grant, grant_oe, irq_service_marker, marker_oe, bus_phase_clock, phase_oe;
    int mismatches = 0, checked = 0;
    logic [31:0] exp_q[$];
    always #2.5 sys_clk = ~sys_clk;
    pbh_primary_bus dut (.sys_clk, .reset_n, .req_valid, .req_read, .req_addr, .req_wdata,
        .req_done, .rsp_rdata, .fetch_addr, .ack_instr, .release_disable_bit, .target_ready,
        .bus_release_request, .float_all_shutdown_n, .address_bus, .address_oe, .data_bus_in,
        .data_bus_out, .data_oe, .access_strobe, .read_not_write, .ctrl_oe, .bus_release_grant,
        .grant_oe, .irq_service_marker, .marker_oe, .bus_phase_clock, .phase_oe);
    pbh_target_model target (.sys_clk, .access_strobe, .read_not_write, .address_bus,
        .wait_cycles, .target_ready, .data_bus_in);
    //----------------------------------------
    // helpers
    //----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one access, bus pins checked every strobed cycle
    task automatic access(input logic rd, input logic [23:0] a, input logic [31:0] d);
        int n;
        logic [31:0] r;
        n = 0;
        r = rnd();
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_read <= rd;
        req_addr <= a;
        req_wdata <= d;
        wait_cycles <= r[3:0];
        if (rd) exp_q.push_back({8'h00, a} ^ 32'hC3C30000);
        do begin
            @(negedge sys_clk);
            n++;
            if (access_strobe === 1'b0) begin
                chk("address", {8'h00, a}, {8'h00, address_bus});
                chk("direction", 32'(rd), 32'(read_not_write));
                if (!rd) chk("wdata", d, data_bus_out);
                chk("oe", 32'({2'b11, !rd}), 32'({address_oe, ctrl_oe, data_oe}));
            end
        end while (req_done !== 1'b1 && n < 80);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        chk("done", 1, 32'(n < 80));
        if (rd) chk("rdata", exp_q.pop_front(), rsp_rdata);
    endtask
    //----------------------------------------
    // tests
    //----------------------------------------
    initial begin
        logic [31:0] r;
        int n;
        @(negedge sys_clk);
        chk("reset oe", 0, 32'({address_oe, data_oe, ctrl_oe}));
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("fetch", 0, 32'(fetch_addr));
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            access(r[31], r[23:0], rnd());
        end
        $display("test accesses done");
        // release requested during an access
        fork
            access(1'b0, 24'h00ABCD, 32'h5A5A0F0F);
            begin
                repeat (2) @(posedge sys_clk);
                bus_release_request <= 1'b0;
            end
        join
        n = 0;
        while (bus_release_grant !== 1'b0 && n < 10) begin
            @(negedge sys_clk);
            n++;
        end
        chk("released", 0, 32'({bus_release_grant, address_oe, ctrl_oe, data_oe}));
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_read <= 1'b1;
        n = 0;
        repeat (8) @(negedge sys_clk) n += (req_done !== 1'b0) || (ctrl_oe !== 1'b0);
        chk("held", 0, n);
        @(posedge sys_clk);
        release_disable_bit <= 1'b1;
        n = 0;
        while (req_done !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        chk("resumed", 32'h3, 32'({n < 40, bus_release_grant}));
        @(posedge sys_clk);
        req_valid <= 1'b0;
        bus_release_request <= 1'b1;
        release_disable_bit <= 1'b0;
        $display("test release done");
        // acknowledge marker and phase clock
        @(posedge sys_clk);
        ack_instr <= 1'b1;
        @(posedge sys_clk);
        ack_instr <= 1'b0;
        n = 0;
        repeat (8) @(negedge sys_clk) n += (irq_service_marker === 1'b0) + (bus_phase_clock === 1'b1);
        chk("marker phase", 5, n);
        $display("test marker done");
        // shutdown floats all pins, reset with shutdown inactive
        @(posedge sys_clk);
        float_all_shutdown_n <= 1'b0;
        repeat (5) @(negedge sys_clk);
        chk("shutdown", 0, 32'({address_oe, data_oe, ctrl_oe, grant_oe, marker_oe, phase_oe}));
        @(posedge sys_clk);
        reset_n <= 1'b0;
        float_all_shutdown_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        access(1'b1, 24'hFFFFFF, 32'h0);
        $display("test shutdown done");
        results();
    end
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
